// file: rtl/rsc_pkg.sv
// Constants shared by the reset source controller files.
package rsc_pkg;
	// Register addresses and the stop unlock value.
	localparam logic [7:0] CLK_CTRL_ADDR = 8'hd4;
	localparam logic [7:0] STOP_UNLOCK_ADDR = 8'hfb;
	localparam logic [7:0] STOP_UNLOCK_VALUE = 8'ha5;
	localparam logic [7:0] STOP_UNLOCK_RESET = 8'h00;
	// Divider field position inside the clock control register.
	localparam int DIV_FIELD_LSB = 3;
	localparam int DIV_FIELD_MSB = 4;
	// Divider selection codes.
	localparam logic [1:0] DIV_BY_1 = 2'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h1;
	localparam logic [1:0] DIV_BY_8 = 2'h2;
	localparam logic [1:0] DIV_BY_16 = 2'h3;
	localparam logic [1:0] DIV_RESET = DIV_BY_16;
	// Bit of the option byte that keeps the voltage detector on in stop mode.
	localparam int OPT_LVD_STOP_BIT = 7;
	// System reset pulse timing.
	localparam int CLK_PERIOD_NS = 50;
	localparam int RST_PULSE_NS = 800;
	localparam int RST_PULSE_CYC = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 5;
endpackage

// file: rtl/rsc_sync.sv
// Two flip-flop synchroniser for a group of asynchronous inputs.
module rsc_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rstn,
	// Asynchronous inputs and their synchronised copies.
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;

	// The first stage feeds only the second stage.
	always_comb
	begin
		meta_next = async_in;
		sync_next = meta_reg;
	end

	// Register both stages.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			meta_reg <= INIT;
			sync_reg <= INIT;
		end
		else
		begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign sync_out = sync_reg;
endmodule // rsc_sync

// file: rtl/rsc_reset_source_controller.sv
// Reset source controller: combines reset sources, stop and back-up control, clock divider register.
// Function
// R1 - Reset pin rising edge with supply above threshold gives a reset in any mode.
// R2 - Enabled watchdog resets the chip on each basic timer overflow; the code ignores overflows in stop mode.
// R3 - Option bit one keeps the voltage detector active in normal and stop mode.
// R4 - Option bit zero disables the voltage detector in stop mode only.
// R5 - In stop mode exactly one of voltage detector or power-on reset is active.
// R6 - Option zero in stop: any enabled external interrupt event resets the chip.
// R7 - Option zero in stop or abnormal state: port falling edge resets regardless of enables.
// R8 - Back-up mode while reset pin is low or supply is below threshold.
// R9 - Pin high and supply rising through threshold gives a reset pulse.
// R10 - Stop, option zero, pin high: low supply does not enter back-up mode.
// R11 - Software writes unlock value before stop; stop only taken with it present.
// R12 - System reset forces control registers to initial values and selects reset vector.
// R13 - After reset the oscillator runs and the slowest divide-by-16 clock is selected.
// R14 - Clock control register is read/write; bits outside the divider field are unused.
// R15 - Divider offers divide by 1, 2, 8 or 16 from bits 4 and 3.
// R16 - Idle wake-up by interrupt leaves the divider selection unchanged.
// R17 - Recovery from stop by reset or external interrupt clears the unlock register.
// R18 - Any enabled source gives one synchronised system reset pulse of fixed length.
// R19 - Watchdog reset requests are ignored during back-up mode.
module rsc_reset_source_controller (
	// Clock and synchronous reset.
	input wire logic clk,
	input wire logic rstn,
	// Pins and analog detector outputs from outside the clock domain.
	input wire logic external_reset_pin_n,
	input wire logic supply_ok,
	input wire logic internal_power_on_reset,
	input wire logic [9:0] ext_interrupt_lines,
	input wire logic [7:0] port_zero,
	input wire logic [3:0] port_two_hi,
	// Non-volatile option byte.
	input wire logic [7:0] option_byte,
	input wire logic reset_vector_opt,
	// Requests from logic on the same clock.
	input wire logic watchdog_enable,
	input wire logic basic_timer_overflow,
	input wire logic [9:0] ext_interrupt_enable,
	input wire logic stop_instr,
	input wire logic abnormal_state,
	// Register port.
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// Status and control outputs.
	output logic sys_reset,
	output logic backup_mode,
	output logic stop_mode,
	output logic osc_enable,
	output logic [1:0] cpu_div_sel,
	output logic lvd_active,
	output logic internal_power_on_reset_active,
	output logic reset_vector_sel
);
	logic pin_s;
	logic ok_s;
	logic por_s;
	logic [9:0] ext_s;
	logic [11:0] port_s;
	logic pin_d_reg, pin_d_next;
	logic ok_d_reg, ok_d_next;
	logic por_d_reg, por_d_next;
	logic [9:0] ext_d_reg, ext_d_next;
	logic [11:0] port_d_reg, port_d_next;
	logic opt_reg, opt_next;
	logic vec_reg, vec_next;
	logic [1:0] div_reg, div_next;
	logic [7:0] unlock_reg, unlock_next;
	logic stop_reg, stop_next;
	logic backup_reg, backup_next;
	logic [rsc_pkg::RST_CNT_W-1:0] cnt_reg, cnt_next;
	logic rst_reg, rst_next;
	logic osc_reg, osc_next;
	logic lvd_act_reg, internal_power_on_reset_act_reg;
	logic [7:0] rdata_reg, rdata_next;
	logic lvd_en, internal_power_on_reset_en;
	logic pin_rise, ok_rise, por_rise;
	logic [9:0] ext_fall;
	logic [11:0] port_fall;
	logic req_pin, req_lvd, req_por, req_wdt, req_ext, req_sed, req_any;
	logic ext_wake;

	// Synchronise the level pins; reset pin and supply idle high, port pins idle high.
	rsc_sync #(.WIDTH(3), .INIT(3'h7)) u_sync_lvl (
		.clk(clk),
		.rstn(rstn),
		.async_in({external_reset_pin_n, supply_ok, internal_power_on_reset}),
		.sync_out({pin_s, ok_s, por_s})
	);
	rsc_sync #(.WIDTH(22), .INIT(22'h3fffff)) u_sync_io (
		.clk(clk),
		.rstn(rstn),
		.async_in({ext_interrupt_lines, port_zero, port_two_hi}),
		.sync_out({ext_s, port_s})
	);

	// Detector enables and edge detection on the synchronised inputs.
	always_comb
	begin
		lvd_en = opt_reg | ~stop_reg; // [R3] [R4]
		internal_power_on_reset_en = ~opt_reg & stop_reg; // [R5]
		pin_rise = pin_s & ~pin_d_reg;
		ok_rise = ok_s & ~ok_d_reg;
		por_rise = por_s & ~por_d_reg;
		ext_fall = ~ext_s & ext_d_reg;
		port_fall = ~port_s & port_d_reg;
	end

	// Reset requests from every source.
	always_comb
	begin
		req_pin = pin_rise & ok_s; // [R1]
		req_lvd = lvd_en & ok_rise & pin_s; // [R9] [R3] [R4]
		req_por = internal_power_on_reset_en & por_rise; // [R5]
		req_wdt = watchdog_enable & basic_timer_overflow & ~stop_reg & ~backup_reg; // [R2] [R19]
		req_ext = ~opt_reg & stop_reg & (|(ext_fall & ext_interrupt_enable)); // [R6]
		req_sed = ~opt_reg & (stop_reg | abnormal_state) & (|port_fall); // [R7]
		req_any = req_pin | req_lvd | req_por | req_wdt | req_ext | req_sed; // [R18]
		ext_wake = opt_reg & stop_reg & (|(ext_fall & ext_interrupt_enable)); // [R17]
	end

	// Next state of edge history, options, registers, stop, back-up and reset pulse.
	always_comb
	begin
		pin_d_next = pin_s;
		ok_d_next = ok_s;
		por_d_next = por_s;
		ext_d_next = ext_s;
		port_d_next = port_s;
		opt_next = opt_reg;
		vec_next = vec_reg;
		div_next = div_reg;
		unlock_next = unlock_reg;
		stop_next = stop_reg;
		// A new request restarts the pulse so sources merge into one pulse.
		if (req_any)
			cnt_next = rsc_pkg::RST_CNT_W'(rsc_pkg::RST_PULSE_CYC); // [R18]
		else if (cnt_reg != '0)
			cnt_next = cnt_reg - rsc_pkg::RST_CNT_W'(1);
		else
			cnt_next = cnt_reg;
		rst_next = (cnt_next != '0);
		// Back-up is a level; with the detector off the supply is not looked at.
		backup_next = ~pin_s | (lvd_en & ~ok_s); // [R8] [R10]
		if (rst_reg)
		begin
			// System reset restores control state and re-reads the options.
			div_next = rsc_pkg::DIV_RESET; // [R12] [R13]
			unlock_next = rsc_pkg::STOP_UNLOCK_RESET; // [R17]
			stop_next = 1'b0; // [R12]
			opt_next = option_byte[rsc_pkg::OPT_LVD_STOP_BIT];
			vec_next = reset_vector_opt; // [R12]
		end
		else
		begin
			// Register writes; idle wake-up never touches the divider.
			if (reg_wr && reg_addr == rsc_pkg::CLK_CTRL_ADDR)
				div_next = reg_wdata[rsc_pkg::DIV_FIELD_MSB:rsc_pkg::DIV_FIELD_LSB]; // [R14] [R15] [R16]
			if (reg_wr && reg_addr == rsc_pkg::STOP_UNLOCK_ADDR)
				unlock_next = reg_wdata;
			// Stop is taken only when software left the unlock value.
			if (stop_instr && unlock_reg == rsc_pkg::STOP_UNLOCK_VALUE && !stop_reg)
				stop_next = 1'b1; // [R11]
			if (ext_wake)
			begin
				stop_next = 1'b0;
				unlock_next = rsc_pkg::STOP_UNLOCK_RESET; // [R17]
			end
		end
		osc_next = ~stop_next & ~backup_next; // [R13]
		// Read data: unused bits of the clock register read as zero.
		if (reg_addr == rsc_pkg::CLK_CTRL_ADDR)
			rdata_next = {3'h0, div_reg, 3'h0}; // [R14]
		else if (reg_addr == rsc_pkg::STOP_UNLOCK_ADDR)
			rdata_next = unlock_reg;
		else
			rdata_next = 8'h00;
	end

	// Register all state; the block reset loads the option byte at the first clean edge.
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			pin_d_reg <= 1'b1;
			ok_d_reg <= 1'b1;
			por_d_reg <= 1'b1;
			ext_d_reg <= 10'h3ff;
			port_d_reg <= 12'hfff;
			opt_reg <= 1'b1;
			vec_reg <= 1'b0;
			div_reg <= rsc_pkg::DIV_RESET;
			unlock_reg <= rsc_pkg::STOP_UNLOCK_RESET;
			stop_reg <= 1'b0;
			backup_reg <= 1'b0;
			cnt_reg <= rsc_pkg::RST_CNT_W'(rsc_pkg::RST_PULSE_CYC);
			rst_reg <= 1'b1;
			osc_reg <= 1'b1;
			lvd_act_reg <= 1'b1;
			internal_power_on_reset_act_reg <= 1'b0;
			rdata_reg <= 8'h00;
		end
		else
		begin
			pin_d_reg <= pin_d_next;
			ok_d_reg <= ok_d_next;
			por_d_reg <= por_d_next;
			ext_d_reg <= ext_d_next;
			port_d_reg <= port_d_next;
			opt_reg <= opt_next;
			vec_reg <= vec_next;
			div_reg <= div_next;
			unlock_reg <= unlock_next;
			stop_reg <= stop_next;
			backup_reg <= backup_next;
			cnt_reg <= cnt_next;
			rst_reg <= rst_next;
			osc_reg <= osc_next;
			lvd_act_reg <= lvd_en;
			internal_power_on_reset_act_reg <= internal_power_on_reset_en;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs straight from flip-flops.
	assign reg_rdata = rdata_reg;
	assign sys_reset = rst_reg;
	assign backup_mode = backup_reg;
	assign stop_mode = stop_reg;
	assign osc_enable = osc_reg;
	assign cpu_div_sel = div_reg;
	assign lvd_active = lvd_act_reg;
	assign internal_power_on_reset_active = internal_power_on_reset_act_reg;
	assign reset_vector_sel = vec_reg;

	// Checks on the reset sources, stop control and divider.
	AST_PIN_RESET: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		(pin_rise && ok_s) |=> sys_reset ##1 sys_reset) else $error("Pin release gave no reset.");
	AST_WDT_RESET: assert property (@(posedge clk) disable iff (!rstn) // [R2]
		(watchdog_enable && basic_timer_overflow && !stop_reg && !backup_reg) |=> sys_reset)
		else $error("Watchdog overflow gave no reset.");
	AST_LVD_OFF_IN_STOP: assert property (@(posedge clk) disable iff (!rstn) // [R4]
		(stop_reg && !opt_reg) |=> !lvd_active) else $error("Detector active in stop with option zero.");
	AST_ONE_SOURCE: assert property (@(posedge clk) disable iff (!rstn) // [R5]
		stop_reg |=> (lvd_active != internal_power_on_reset_active)) else $error("Stop source selection not exclusive.");
	AST_SED_RESET: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		(!opt_reg && abnormal_state && (|port_fall)) |=> sys_reset) else $error("Port edge gave no reset.");
	AST_BACKUP_PIN: assert property (@(posedge clk) disable iff (!rstn) // [R8]
		!pin_s |=> backup_mode) else $error("Low reset pin without back-up mode.");
	AST_NO_BACKUP_STOP: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		(stop_reg && !opt_reg && pin_s) |=> !backup_mode) else $error("Back-up entered in stop with option zero.");
	AST_STOP_LOCKED: assert property (@(posedge clk) disable iff (!rstn) // [R11]
		(stop_instr && !stop_reg && unlock_reg != rsc_pkg::STOP_UNLOCK_VALUE) |=> !stop_mode)
		else $error("Stop taken without unlock value.");
	AST_DIV_AFTER_RESET: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		$fell(sys_reset) |-> cpu_div_sel == rsc_pkg::DIV_BY_16) else $error("Divider not slowest after reset.");
	AST_STOP_CLEARS: assert property (@(posedge clk) disable iff (!rstn) // [R17]
		$fell(stop_mode) |-> unlock_reg == rsc_pkg::STOP_UNLOCK_RESET) else $error("Unlock not cleared on stop exit.");
	AST_PULSE_LEN: assert property (@(posedge clk) disable iff (!rstn) // [R18]
		$rose(sys_reset) |-> sys_reset [*8]) else $error("Reset pulse too short.");
	AST_WDT_BACKUP: assert property (@(posedge clk) disable iff (!rstn) // [R19]
		(backup_reg && cnt_reg == '0 && !req_pin && !req_lvd && !req_por && !req_sed && !req_ext) |=> !sys_reset)
		else $error("Reset raised during back-up without a source.");
	COV_STOP_ENTRY: cover property (@(posedge clk) disable iff (!rstn) $rose(stop_mode));
	COV_EXT_RESET: cover property (@(posedge clk) disable iff (!rstn) req_ext);
	COV_LVD_RESET: cover property (@(posedge clk) disable iff (!rstn) req_lvd);
	COV_WDT_RESET: cover property (@(posedge clk) disable iff (!rstn) req_wdt);
endmodule // rsc_reset_source_controller

// file: sim/rsc_far_model.sv
// Far-side model of the reset pin, supply detector, power-on circuit and port pins.
module rsc_far_model (
	// Requests from the bench.
	input wire logic pin_low,
	input wire logic supply_low,
	input wire logic por_high,
	input wire logic [7:0] p0_low,
	input wire logic [3:0] p2_low,
	input wire logic [9:0] irq_low,
	// Lines seen by the controller.
	output logic external_reset_pin_n,
	output logic supply_ok,
	output logic internal_power_on_reset,
	output logic [7:0] port_zero,
	output logic [3:0] port_two_hi,
	output logic [9:0] ext_interrupt_lines
);
	timeunit 1ns;
	timeprecision 1ps;
	// Pins idle high through pull-ups and fall only when the bench asks; the power-on line idles low and rises on por_high.
	assign external_reset_pin_n = !pin_low;
	assign supply_ok = !supply_low;
	assign internal_power_on_reset = por_high;
	assign port_zero = ~p0_low;
	assign port_two_hi = ~p2_low;
	assign ext_interrupt_lines = ~irq_low;
endmodule // rsc_far_model

// file: sim/tb_reset_source_controller.sv
// Self-checking bench for the reset source controller.
module tb_reset_source_controller;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rstn = 0, pin_low = 0, supply_low = 0, por_high = 0, reset_vector_opt = 0;
	logic [7:0] p0_low = '0, option_byte = 8'h80, reg_addr = '0, reg_wdata = '0, reg_rdata;
	logic [3:0] p2_low = '0, port_two_hi;
	logic [9:0] irq_low = '0, ext_interrupt_lines, ext_interrupt_enable = '0;
	logic watchdog_enable = 0, basic_timer_overflow = 0, stop_instr = 0, abnormal_state = 0, reg_wr = 0;
	logic external_reset_pin_n, supply_ok, internal_power_on_reset, sys_reset, backup_mode, stop_mode;
	logic osc_enable, lvd_active, internal_power_on_reset_active, reset_vector_sel;
	logic [7:0] port_zero;
	logic [1:0] cpu_div_sel;
	logic [31:0] rnd = 32'h8633;
	int n_fail = 0, check_count = 0, exp_div;
	// The clock toggles every 25 ns, half of the 50 ns period.
	always #25 clk = !clk;
	rsc_far_model i_far (.pin_low(pin_low), .supply_low(supply_low), .por_high(por_high), .p0_low(p0_low),
		.p2_low(p2_low), .irq_low(irq_low), .external_reset_pin_n(external_reset_pin_n), .supply_ok(supply_ok),
		.internal_power_on_reset(internal_power_on_reset), .port_zero(port_zero), .port_two_hi(port_two_hi),
		.ext_interrupt_lines(ext_interrupt_lines));
	rsc_reset_source_controller i_dut (.clk(clk), .rstn(rstn), .external_reset_pin_n(external_reset_pin_n),
		.supply_ok(supply_ok), .internal_power_on_reset(internal_power_on_reset),
		.ext_interrupt_lines(ext_interrupt_lines), .port_zero(port_zero), .port_two_hi(port_two_hi),
		.option_byte(option_byte), .reset_vector_opt(reset_vector_opt), .watchdog_enable(watchdog_enable),
		.basic_timer_overflow(basic_timer_overflow), .ext_interrupt_enable(ext_interrupt_enable),
		.stop_instr(stop_instr), .abnormal_state(abnormal_state), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sys_reset(sys_reset), .backup_mode(backup_mode),
		.stop_mode(stop_mode), .osc_enable(osc_enable), .cpu_div_sel(cpu_div_sel), .lvd_active(lvd_active),
		.internal_power_on_reset_active(internal_power_on_reset_active), .reset_vector_sel(reset_vector_sel));
	// Prints the verdict and ends the run.
	task automatic test_done();
		if (n_fail == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Compares one seen value with its expected value.
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Advances a number of falling edges.
	task automatic step(input int n);
		repeat (n) @(negedge clk);
	endtask
	// Steps the pseudo-random source.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// Writes one register in a single cycle.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		step(1);
		reg_wr = 0;
	endtask
	// Reads one register and compares it.
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		step(2);
		chk("reg_rdata", reg_rdata, e);
	endtask
	// Pulses a same-clock request for one cycle.
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
	endtask
	// Waits for a reset pulse and measures its length; then checks the divider and stop mode.
	task automatic wait_rst();
		int n;
		n = 0;
		while (sys_reset !== 1'b1 && n < 20)
		begin
			step(1);
			n++;
		end
		chk("sys_reset_rise", n < 20, 1'b1);
		if (n >= 20)
			test_done();
		n = 0;
		while (sys_reset === 1'b1 && n < 40)
		begin
			step(1);
			n++;
		end
		chk("pulse_length", n, rsc_pkg::RST_PULSE_CYC);
		exp_div = 3;
		chk("cpu_div_sel", cpu_div_sel, exp_div[1:0]);
		chk("stop_mode", stop_mode, 1'b0);
	endtask
	// Loads the unlock value and executes the stop request.
	task automatic enter_stop();
		wr(rsc_pkg::STOP_UNLOCK_ADDR, rsc_pkg::STOP_UNLOCK_VALUE);
		pulse(stop_instr);
		step(1);
		chk("stop_mode", stop_mode, 1'b1);
		chk("osc_enable", osc_enable, 1'b0);
	endtask
	// Main sequence of scenarios.
	initial
	begin
		step(6);
		rstn = 1;
		wait_rst();
		chk("osc_enable", osc_enable, 1'b1);
		rd(8'hd4, 8'h18);
		rd(8'h00, 8'h00);
		for (int k = 0; k < 4; k++)
		begin
			rnd = lfsr(rnd);
			wr(8'hd4, {rnd[7:5], k[1:0], rnd[2:0]});
			chk("cpu_div_sel", cpu_div_sel, k[1:0]);
			rd(8'hd4, {3'h0, k[1:0], 3'h0});
			wr(8'h10, rnd[15:8]);
			rd(8'h10, 8'h00);
		end
		pulse(stop_instr);
		step(1);
		chk("stop_mode", stop_mode, 1'b0);
		option_byte = 8'h7f;
		reset_vector_opt = 1;
		watchdog_enable = 1;
		pulse(basic_timer_overflow);
		wait_rst();
		chk("reset_vector_sel", reset_vector_sel, 1'b1);
		pin_low = 1;
		step(6);
		chk("backup_mode", backup_mode, 1'b1);
		pulse(basic_timer_overflow);
		step(20);
		chk("sys_reset", sys_reset, 1'b0);
		watchdog_enable = 0;
		pin_low = 0;
		wait_rst();
		chk("lvd_active", lvd_active, 1'b1);
		supply_low = 1;
		step(6);
		chk("backup_mode", backup_mode, 1'b1);
		supply_low = 0;
		wait_rst();
		enter_stop();
		chk("lvd_active", lvd_active, 1'b0);
		chk("internal_power_on_reset_active", internal_power_on_reset_active, 1'b1);
		supply_low = 1;
		step(8);
		chk("backup_mode", backup_mode, 1'b0);
		supply_low = 0;
		rnd = lfsr(rnd);
		p0_low[rnd[2:0]] = 1;
		wait_rst();
		p0_low = '0;
		rd(rsc_pkg::STOP_UNLOCK_ADDR, rsc_pkg::STOP_UNLOCK_RESET);
		// An abnormal state outside stop lets a falling edge on port two reset the chip.
		abnormal_state = 1;
		rnd = lfsr(rnd);
		p2_low[rnd[1:0]] = 1;
		wait_rst();
		p2_low = '0;
		abnormal_state = 0;
		enter_stop();
		ext_interrupt_enable = 10'h001;
		irq_low[0] = 1;
		wait_rst();
		irq_low = '0;
		enter_stop();
		por_high = 1;
		wait_rst();
		por_high = 0;
		option_byte = 8'h80;
		watchdog_enable = 1;
		pulse(basic_timer_overflow);
		wait_rst();
		watchdog_enable = 0;
		enter_stop();
		chk("lvd_active", lvd_active, 1'b1);
		chk("internal_power_on_reset_active", internal_power_on_reset_active, 1'b0);
		supply_low = 1;
		step(6);
		chk("backup_mode", backup_mode, 1'b1);
		supply_low = 0;
		wait_rst();
		// With option one an enabled interrupt wakes from stop without a reset.
		enter_stop();
		irq_low[0] = 1;
		step(4);
		chk("stop_mode", stop_mode, 1'b0);
		chk("sys_reset", sys_reset, 1'b0);
		chk("osc_enable", osc_enable, 1'b1);
		irq_low = '0;
		rd(rsc_pkg::STOP_UNLOCK_ADDR, rsc_pkg::STOP_UNLOCK_RESET);
		test_done();
	end
endmodule // tb_reset_source_controller
